// >>> tts_map.svh
// Register offsets, field positions, reset values and timing figures of the trip test sequencer.
`ifndef TTS_MAP_SVH
`define TTS_MAP_SVH

// Register byte addresses on the APB side.
`define TTS_CTRL_ADDR 8'h00
`define TTS_STATUS_ADDR 8'h04
`define TTS_IRQ_STAT_ADDR 8'h08
`define TTS_IRQ_CLR_ADDR 8'h0c
`define TTS_IRQ_EN_ADDR 8'h10

// Control register fields.
`define TTS_CTRL_ENABLE 0
`define TTS_CTRL_REAL 1
`define TTS_CTRL_THREE 2
`define TTS_CTRL_GBT 3
`define TTS_CTRL_START 4

// Control register reset values.
`define TTS_RST_ENABLE 1'b0
`define TTS_RST_GBT 1'b1

// Interrupt status bits.
`define TTS_EV_DONE 0
`define TTS_EV_FAIL 1
`define TTS_EV_RESP 2
`define TTS_EV_IGNORED 3
`define TTS_EV_W 4

// Time figures in milliseconds.
`define TTS_OFF_LONG_MS 16'd2000
`define TTS_OFF_SHORT_MS 16'd1500
`define TTS_KEY_LONG_MS 16'd2000
`define TTS_KEY_SHORT_MS 16'd500
`define TTS_REPLY_WAIT_MS 16'd6000

// Timebase: one millisecond in nanoseconds and the clock period in nanoseconds.
`define TTS_MS_NS 1000000
`define TTS_CLK_NS 25

`endif

// >>> tts_pkg.sv
// Types shared by the trip test sequencer modules.
package tts_pkg;

	typedef enum logic [2:0] {
		TTS_IDLE,
		TTS_I_OFF,
		TTS_I_KEY,
		TTS_I_WAIT,
		TTS_R_OFF,
		TTS_R_KEY
	} tts_state_e;

	typedef struct packed {
		tts_state_e state;
		logic hi;
		logic real_m;
		logic three;
		logic enable;
		logic gbt;
		logic panel_q;
		logic init_q;
		logic [3:0] irq_stat;
		logic [3:0] irq_en;
		logic tmr_start;
		logic [15:0] tmr_load;
		logic tx_off;
		logic tx_lo;
		logic tx_hi;
		logic trip_out;
		logic echo_out;
		logic first_echo;
		logic ub_echo;
		logic irq;
		logic busy;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic last_ok;
		logic last_fail;
	} tts_seq_s;

	typedef struct packed {
		logic [31:0] pre;
		logic [15:0] ms;
	} tts_tmr_s;

	typedef struct packed {
		logic quiet_guard;
		logic prev_lo;
		logic prev_hi;
		logic lo_loss;
		logic hi_loss;
		logic lo_guard;
		logic hi_guard;
	} tts_rx_s;

endpackage

// >>> tts_if.sv
// Interfaces between the sequencer, its interval timer and its receive classifier.
`timescale 1ns/1ps
interface tts_tmr_if;
	logic start;
	logic [15:0] load_ms;
	logic expired;
	modport seq(output start, output load_ms, input expired);
	modport tmr(input start, input load_ms, output expired);
endinterface

interface tts_rx_if;
	logic lo_loss;
	logic hi_loss;
	logic lo_guard;
	logic hi_guard;
	modport cls(output lo_loss, output hi_loss, output lo_guard, output hi_guard);
	modport seq(input lo_loss, input hi_loss, input lo_guard, input hi_guard);
endinterface

// >>> tts_timer.sv
// Millisecond interval timer used for the keying intervals.
`timescale 1ns/1ps
`include "tts_map.svh"
module tts_timer import tts_pkg::*; #(
	parameter int CYC_PER_MS = (`TTS_MS_NS + `TTS_CLK_NS - 1) / `TTS_CLK_NS
) (
	input wire logic pclk, // System clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic ce, // Clock enable; state holds while low.
	tts_tmr_if.tmr tmr // Load request and expiry flag.
);

	if (CYC_PER_MS < 1) begin : g_chk
		$error("tts_timer: CYC_PER_MS must be at least one");
	end

	tts_tmr_s st;
	tts_tmr_s next_st;

	// A load restarts the prescaler; otherwise each full millisecond takes one off the count until it reaches zero.
	always_comb begin
		next_st = st;
		if (tmr.start) begin
			next_st.ms = tmr.load_ms;
			next_st.pre = '0;
		end else if (st.ms != 16'h0) begin
			if (st.pre == 32'(CYC_PER_MS - 1)) begin
				next_st.pre = '0;
				next_st.ms = st.ms - 16'h1;
			end else begin
				next_st.pre = st.pre + 32'h1;
			end
		end
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// The interval has run out once the count reaches zero.
	assign tmr.expired = (st.ms == 16'h0);

	a_tmr_load: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && tmr.start && tmr.load_ms != 16'h0) |=> !tmr.expired)
		else $error("timer expired right after a nonzero load");

endmodule

// >>> tts_rx_class.sv
// Classifies each trip tone onset by what the channel held just before it.
`timescale 1ns/1ps
module tts_rx_class import tts_pkg::*; (
	input wire logic pclk, // System clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic ce, // Clock enable; state holds while low.
	input wire logic rx_guard, // Receiver detects the guard tone.
	input wire logic rx_trip_lo, // Receiver detects the low trip tone.
	input wire logic rx_trip_hi, // Receiver detects the high trip tone.
	tts_rx_if.cls rx // Onset pulses, sorted by prior channel state.
);

	tts_rx_s st;
	tts_rx_s next_st;

	// Guard remembers a healthy channel; silence remembers loss of channel.
	always_comb begin
		next_st = st;
		next_st.prev_lo = rx_trip_lo;
		next_st.prev_hi = rx_trip_hi;
		if (rx_guard) begin
			next_st.quiet_guard = 1'b1;
		end else if (!rx_trip_lo && !rx_trip_hi) begin
			next_st.quiet_guard = 1'b0;
		end
		next_st.lo_loss = rx_trip_lo & ~st.prev_lo & ~st.quiet_guard;
		next_st.hi_loss = rx_trip_hi & ~st.prev_hi & ~st.quiet_guard;
		next_st.lo_guard = rx_trip_lo & ~st.prev_lo & st.quiet_guard;
		next_st.hi_guard = rx_trip_hi & ~st.prev_hi & st.quiet_guard;
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Onset pulses to the sequencer.
	assign rx.lo_loss = st.lo_loss;
	assign rx.hi_loss = st.hi_loss;
	assign rx.lo_guard = st.lo_guard;
	assign rx.hi_guard = st.hi_guard;

	a_rx_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
		!(st.lo_loss && st.lo_guard))
		else $error("trip onset classed as both genuine and test");

endmodule

// >>> tts_seq.sv
// Trip test sequencer top: keying sequence, remote answer, receive outputs and APB registers.
// Functional notes
// - Real-trip mode: on start, transmitter keyed off for 2 s.
// - Real-trip mode: then keyed onto the trip frequency for 2 s.
// - Real-trip remote: on test command, assert echo trip and key trip 2 s.
// - Real-trip initiator: returned trip raises both trip and echo trip outputs.
// - Trip test works only with guard-before-trip receive logic configured.
// - Echo-trip mode: initiator keyed off 1.5 s, then trip frequency 0.5 s.
// - Echo-trip remote: assert echo trip, key off 2 s, then trip 0.5 s.
// - Echo-trip initiator: loss then trip gives echo trip only, never real trip.
// - Real-trip mode only for two-frequency; three-frequency forces echo-trip mode.
// - Three-frequency test checks direct trip on low, unblock trip on high.
// - Three-frequency initiator: key off 1.5 s, then low trip frequency 0.5 s.
// - Three-frequency remote: first echo output, key off 2 s, low trip 0.5 s.
// - Three-frequency initiator: reply gives direct-trip echo output, no trip output.
// - After direct-trip check, unblock check is sent and returned the same way.
// - Start on panel command, web request via register, or initiate input.
`timescale 1ns/1ps
`include "tts_map.svh"
module tts_seq import tts_pkg::*; #(
	parameter int CYC_PER_MS = (`TTS_MS_NS + `TTS_CLK_NS - 1) / `TTS_CLK_NS,
	parameter logic [15:0] REPLY_WAIT_MS = `TTS_REPLY_WAIT_MS
) (
	input wire logic pclk, // System clock, 40 MHz.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic ce, // Clock enable; all state holds while low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB write direction.
	input wire logic [7:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error for unmapped address.
	input wire logic panel_start, // Front panel test command.
	input wire logic init_req, // Trip test initiate input.
	input wire logic rx_guard, // Receiver sees guard tone.
	input wire logic rx_trip_lo, // Receiver sees low trip tone.
	input wire logic rx_trip_hi, // Receiver sees high trip tone.
	output logic tx_off, // Transmitter keyed off.
	output logic tx_lo, // Transmitter shifted to low trip frequency.
	output logic tx_hi, // Transmitter shifted to high trip frequency.
	output logic trip_out, // Genuine trip output.
	output logic echo_trip_out, // Echo trip (direct-trip echo in three-frequency).
	output logic first_echo_trip_output, // Remote-side first echo trip, three-frequency.
	output logic unblock_echo_out, // Unblock echo trip, three-frequency.
	output logic busy, // Sequence in progress.
	output logic irq // Level interrupt.
);

	if (CYC_PER_MS < 1 || REPLY_WAIT_MS == 16'h0) begin : g_chk
		$error("tts_seq: CYC_PER_MS and REPLY_WAIT_MS must be nonzero");
	end

	localparam tts_seq_s SEQ_RST = '{state: TTS_IDLE, gbt: `TTS_RST_GBT, enable: `TTS_RST_ENABLE, default: '0};

	tts_seq_s st;
	tts_seq_s next_st;
	tts_tmr_if tmr_if();
	tts_rx_if rx_if();
	logic tmr_done;
	logic start_any;
	logic go_ok;
	logic setup_ph;
	logic wr_acc;
	logic [3:0] ev;

	tts_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tmr (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.tmr(tmr_if.tmr)
	);

	tts_rx_class u_rx (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.rx_guard(rx_guard),
		.rx_trip_lo(rx_trip_lo),
		.rx_trip_hi(rx_trip_hi),
		.rx(rx_if.cls)
	);

	// Timer requests come from registered state.
	assign tmr_if.start = st.tmr_start;
	assign tmr_if.load_ms = st.tmr_load;

	// Shared decode terms; a load in flight masks the stale expiry flag.
	assign tmr_done = tmr_if.expired & ~st.tmr_start;
	assign setup_ph = psel & ~penable;
	assign wr_acc = psel & penable & pwrite & st.pready;
	assign start_any = (panel_start & ~st.panel_q) | (init_req & ~st.init_q)
		| (wr_acc && paddr == `TTS_CTRL_ADDR && pwdata[`TTS_CTRL_START]);
	assign go_ok = st.enable & st.gbt;

	// Next-state logic: register access, sequence and interrupt bookkeeping.
	always_comb begin
		next_st = st;
		ev = '0;
		next_st.tmr_start = 1'b0;
		next_st.panel_q = panel_start;
		next_st.init_q = init_req;
		next_st.pready = setup_ph;
		if (setup_ph) begin
			next_st.prdata = '0;
			next_st.pslverr = 1'b0;
			if (paddr == `TTS_CTRL_ADDR) begin
				next_st.prdata[`TTS_CTRL_ENABLE] = st.enable;
				next_st.prdata[`TTS_CTRL_REAL] = st.real_m;
				next_st.prdata[`TTS_CTRL_THREE] = st.three;
				next_st.prdata[`TTS_CTRL_GBT] = st.gbt;
			end else if (paddr == `TTS_STATUS_ADDR) begin
				next_st.prdata[10:0] = {st.hi, st.ub_echo, st.first_echo, st.echo_out, st.trip_out,
					st.last_fail, st.last_ok, st.state != TTS_IDLE, st.state};
			end else if (paddr == `TTS_IRQ_STAT_ADDR) begin
				next_st.prdata[3:0] = st.irq_stat;
			end else if (paddr == `TTS_IRQ_EN_ADDR) begin
				next_st.prdata[3:0] = st.irq_en;
			end else if (paddr != `TTS_IRQ_CLR_ADDR) begin
				next_st.pslverr = 1'b1;
			end
		end
		if (wr_acc && paddr == `TTS_CTRL_ADDR) begin
			next_st.enable = pwdata[`TTS_CTRL_ENABLE];
			next_st.three = pwdata[`TTS_CTRL_THREE];
			next_st.real_m = pwdata[`TTS_CTRL_REAL] & ~pwdata[`TTS_CTRL_THREE];
			next_st.gbt = pwdata[`TTS_CTRL_GBT];
		end else if (wr_acc && paddr == `TTS_IRQ_EN_ADDR) begin
			next_st.irq_en = pwdata[3:0];
		end
		// Sequence: initiator keys off, keys trip, waits for the answer; responder answers.
		case (st.state)
			TTS_IDLE: begin
				if (start_any && go_ok) begin
					next_st.state = TTS_I_OFF;
					next_st.hi = 1'b0;
					next_st.trip_out = 1'b0;
					next_st.echo_out = 1'b0;
					next_st.first_echo = 1'b0;
					next_st.ub_echo = 1'b0;
					next_st.last_ok = 1'b0;
					next_st.last_fail = 1'b0;
					next_st.tx_off = 1'b1;
					next_st.tmr_start = 1'b1;
					next_st.tmr_load = st.real_m ? `TTS_OFF_LONG_MS : `TTS_OFF_SHORT_MS;
				end else if (go_ok && rx_if.lo_loss) begin
					ev[`TTS_EV_RESP] = 1'b1;
					next_st.hi = 1'b0;
					next_st.first_echo = st.three | st.first_echo;
					next_st.echo_out = ~st.three | st.echo_out;
					next_st.tmr_start = 1'b1;
					if (st.real_m) begin
						next_st.state = TTS_R_KEY;
						next_st.tx_lo = 1'b1;
						next_st.tmr_load = `TTS_KEY_LONG_MS;
					end else begin
						next_st.state = TTS_R_OFF;
						next_st.tx_off = 1'b1;
						next_st.tmr_load = `TTS_OFF_LONG_MS;
					end
				end else if (go_ok && st.three && rx_if.hi_loss) begin
					ev[`TTS_EV_RESP] = 1'b1;
					next_st.hi = 1'b1;
					next_st.ub_echo = 1'b1;
					next_st.state = TTS_R_OFF;
					next_st.tx_off = 1'b1;
					next_st.tmr_start = 1'b1;
					next_st.tmr_load = `TTS_OFF_LONG_MS;
				end
			end
			TTS_I_OFF: begin
				if (tmr_done) begin
					next_st.state = TTS_I_KEY;
					next_st.tx_off = 1'b0;
					next_st.tx_lo = ~st.hi;
					next_st.tx_hi = st.hi;
					next_st.tmr_start = 1'b1;
					next_st.tmr_load = st.real_m ? `TTS_KEY_LONG_MS : `TTS_KEY_SHORT_MS;
				end
			end
			TTS_I_KEY: begin
				if (tmr_done) begin
					next_st.state = TTS_I_WAIT;
					next_st.tx_lo = 1'b0;
					next_st.tx_hi = 1'b0;
					next_st.tmr_start = 1'b1;
					next_st.tmr_load = REPLY_WAIT_MS;
				end
			end
			TTS_I_WAIT: begin
				if (st.real_m && rx_if.lo_guard) begin
					next_st.trip_out = 1'b1;
					next_st.echo_out = 1'b1;
					next_st.state = TTS_IDLE;
					next_st.last_ok = 1'b1;
					ev[`TTS_EV_DONE] = 1'b1;
				end else if (!st.real_m && !st.hi && rx_if.lo_loss) begin
					next_st.echo_out = 1'b1;
					if (st.three) begin
						next_st.hi = 1'b1;
						next_st.state = TTS_I_OFF;
						next_st.tx_off = 1'b1;
						next_st.tmr_start = 1'b1;
						next_st.tmr_load = `TTS_OFF_SHORT_MS;
					end else begin
						next_st.state = TTS_IDLE;
						next_st.last_ok = 1'b1;
						ev[`TTS_EV_DONE] = 1'b1;
					end
				end else if (st.hi && rx_if.hi_loss) begin
					next_st.ub_echo = 1'b1;
					next_st.state = TTS_IDLE;
					next_st.last_ok = 1'b1;
					ev[`TTS_EV_DONE] = 1'b1;
				end else if (tmr_done) begin
					next_st.state = TTS_IDLE;
					next_st.last_fail = 1'b1;
					ev[`TTS_EV_FAIL] = 1'b1;
				end
			end
			TTS_R_OFF: begin
				if (tmr_done) begin
					next_st.state = TTS_R_KEY;
					next_st.tx_off = 1'b0;
					next_st.tx_lo = ~st.hi;
					next_st.tx_hi = st.hi;
					next_st.tmr_start = 1'b1;
					next_st.tmr_load = `TTS_KEY_SHORT_MS;
				end
			end
			TTS_R_KEY: begin
				if (tmr_done) begin
					next_st.state = TTS_IDLE;
					next_st.tx_lo = 1'b0;
					next_st.tx_hi = 1'b0;
				end
			end
			default: begin
				next_st.state = TTS_IDLE;
			end
		endcase
		ev[`TTS_EV_IGNORED] = start_any & (st.state != TTS_IDLE);
		// A new event wins over a clear written in the same cycle.
		next_st.irq_stat = st.irq_stat & ~((wr_acc && paddr == `TTS_IRQ_CLR_ADDR) ? pwdata[3:0] : 4'h0) | ev;
		next_st.irq = |(next_st.irq_stat & next_st.irq_en);
		next_st.busy = (next_st.state != TTS_IDLE);
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= SEQ_RST;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register.
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign tx_off = st.tx_off;
	assign tx_lo = st.tx_lo;
	assign tx_hi = st.tx_hi;
	assign trip_out = st.trip_out;
	assign echo_trip_out = st.echo_out;
	assign first_echo_trip_output = st.first_echo;
	assign unblock_echo_out = st.ub_echo;
	assign busy = st.busy;
	assign irq = st.irq;

	a_real_off_time: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && st.state == TTS_IDLE && start_any && go_ok && st.real_m)
		|=> (st.state == TTS_I_OFF && st.tx_off && st.tmr_load == `TTS_OFF_LONG_MS))
		else $error("real-trip start did not key off for the long interval");

	a_real_key_time: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && st.state == TTS_I_OFF && tmr_done && st.real_m)
		|=> (st.tx_lo && !st.tx_off && st.tmr_load == `TTS_KEY_LONG_MS))
		else $error("real-trip key interval wrong");

	a_resp_real: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && st.state == TTS_IDLE && !start_any && go_ok && st.real_m && rx_if.lo_loss)
		|=> (st.state == TTS_R_KEY && st.echo_out && st.tx_lo && st.tmr_load == `TTS_KEY_LONG_MS))
		else $error("real-trip responder did not echo and key");

	a_real_trip_out: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && st.state == TTS_I_WAIT && st.real_m && rx_if.lo_guard) |=> (st.trip_out && st.echo_out))
		else $error("returned trip did not raise trip and echo");

	a_gbt_needed: assert property (@(posedge pclk) disable iff (!presetn)
		(st.state == TTS_IDLE && !st.gbt) |=> (st.state == TTS_IDLE))
		else $error("sequence left idle without guard-before-trip");

	a_cb_off_time: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && st.state == TTS_IDLE && start_any && go_ok && !st.real_m)
		|=> (st.tmr_load == `TTS_OFF_SHORT_MS) ##1 (st.state == TTS_I_OFF && st.tx_off))
		else $error("echo-trip start used wrong off interval");

	a_resp_cb_key: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && st.state == TTS_R_OFF && tmr_done) |=> (st.state == TTS_R_KEY && st.tmr_load == `TTS_KEY_SHORT_MS))
		else $error("echo-trip responder key interval wrong");

	a_cb_no_trip: assert property (@(posedge pclk) disable iff (!presetn)
		(st.state == TTS_I_WAIT && !st.real_m) |=> !st.trip_out)
		else $error("echo-trip mode raised the trip output");

	a_three_no_real: assert property (@(posedge pclk) disable iff (!presetn)
		st.three |-> !st.real_m)
		else $error("real-trip mode active with three-frequency");

	a_ub_phase: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && st.state == TTS_I_WAIT && st.three && !st.hi && rx_if.lo_loss)
		|=> (st.hi && st.state == TTS_I_OFF && st.echo_out && !st.trip_out))
		else $error("unblock check did not follow direct-trip check");

	a_busy_ignores: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && st.state == TTS_I_OFF && !tmr_done && start_any) |=> (st.state == TTS_I_OFF && st.irq_stat[`TTS_EV_IGNORED]))
		else $error("start accepted while busy");

endmodule

// >>> tts_remote.sv
// Behavioural far-end carrier terminal that answers the local trip test.
`timescale 1ns/1ps
module tts_remote #(
	parameter int CYC_PER_MS = 2
) (
	input wire logic pclk, // System clock.
	input wire logic tx_off, // Local transmitter keyed off.
	input wire logic tx_lo, // Local transmitter on the low trip tone.
	input wire logic tx_hi, // Local transmitter on the high trip tone.
	input wire logic real_m, // Far end is set for a real trip.
	input wire logic mute, // Far end ignores test commands.
	input wire logic go, // Far end starts its own echo test.
	output logic rx_guard, // Guard tone heard locally.
	output logic rx_trip_lo, // Low trip tone heard locally.
	output logic rx_trip_hi // High trip tone heard locally.
);
	logic off_k;
	logic loss;
	logic hi;

	// The local receiver hears guard unless the far end is keyed off or shifted.
	assign rx_guard = !off_k && !rx_trip_lo && !rx_trip_hi;

	// Holds the far transmitter in one state for a number of milliseconds; the caller releases it at the end.
	task automatic key(input logic o, input logic l, input logic h, input int ms);
		off_k <= o;
		rx_trip_lo <= l;
		rx_trip_hi <= h;
		repeat (ms * CYC_PER_MS) @(posedge pclk);
	endtask

	// A trip tone after loss of channel is a test command, answered once the tone ends.
	initial begin
		off_k = 1'b0;
		rx_trip_lo = 1'b0;
		rx_trip_hi = 1'b0;
		loss = 1'b0;
		hi = 1'b0;
		forever begin
			@(posedge pclk);
			if (go) begin
				key(1'b1, 1'b0, 1'b0, 1500);
				key(1'b0, 1'b1, 1'b0, 500);
				key(1'b0, 1'b0, 1'b0, 0);
			end else if (tx_off) begin
				loss = 1'b1;
			end else if ((tx_lo || tx_hi) && loss && !mute) begin
				hi = tx_hi;
				while (tx_lo || tx_hi) @(posedge pclk);
				loss = 1'b0;
				if (real_m) begin
					key(1'b0, 1'b1, 1'b0, 2000);
				end else begin
					key(1'b1, 1'b0, 1'b0, 2000);
					key(1'b0, !hi, hi, 500);
				end
				key(1'b0, 1'b0, 1'b0, 0);
			end else if (tx_lo || tx_hi) begin
				loss = 1'b0;
			end
		end
	end
endmodule

// >>> testbench.sv
// Self-checking bench for the trip test sequencer against a far-end model.
`timescale 1ns/1ps
`include "tts_map.svh"
module testbench;
	localparam int CYC = 2;
	logic pclk, presetn, ce, psel, penable, pwrite, real_m, mute, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic pready, pslverr, rx_guard, rx_trip_lo, rx_trip_hi, tx_off, tx_lo, tx_hi;
	logic trip_out, echo_trip_out, first_echo_trip_output, unblock_echo_out, busy, irq;
	logic [2:0] trig;
	logic [2:0] txv;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;

	assign txv = {tx_hi, tx_lo, tx_off};

	// Sequencer with a short millisecond and a reply wait that still covers the far answer.
	tts_seq #(.CYC_PER_MS(CYC), .REPLY_WAIT_MS(16'd3000)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .panel_start(trig[0]), .init_req(trig[1]), .rx_guard(rx_guard),
		.rx_trip_lo(rx_trip_lo), .rx_trip_hi(rx_trip_hi), .tx_off(tx_off), .tx_lo(tx_lo), .tx_hi(tx_hi),
		.trip_out(trip_out), .echo_trip_out(echo_trip_out), .first_echo_trip_output(first_echo_trip_output),
		.unblock_echo_out(unblock_echo_out), .busy(busy), .irq(irq));

	// Far terminal across the line.
	tts_remote #(.CYC_PER_MS(CYC)) u_far (.pclk(pclk), .tx_off(tx_off), .tx_lo(tx_lo), .tx_hi(tx_hi),
		.real_m(real_m), .mute(mute), .go(trig[2]), .rx_guard(rx_guard), .rx_trip_lo(rx_trip_lo),
		.rx_trip_hi(rx_trip_hi));

	// Free-running 40 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// Cuts a hung run short.
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			miscompares++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] x, input string m);
		num_checks++;
		if (got !== x) begin
			miscompares++;
			$display("BAD %0t %s got %h expected %h", $time, m, got, x);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string m);
		apb(1'b0, a, 32'h0);
		chk(q, x, m);
	endtask

	task automatic fire(input logic [2:0] t);
		@(posedge pclk);
		trig <= t;
		@(posedge pclk);
		trig <= 3'b000;
	endtask

	task automatic span(input int i, input int ms, input string m);
		int n;
		n = 0;
		while (txv[i] !== 1'b1 && n < 40000) @(posedge pclk) n++;
		n = 0;
		while (txv[i] === 1'b1) @(posedge pclk) n++;
		chk(32'(n >= ms * CYC - 1 && n <= ms * CYC + 4), 32'h1, m);
	endtask

	task automatic idle_wait();
		int n;
		n = 0;
		while ((busy !== 1'b0 || rx_guard !== 1'b1) && n < 40000) @(posedge pclk) n++;
		@(negedge pclk);
		chk(32'(busy), 32'h0, "sequence stuck");
	endtask

	// Reset, register checks, then each kind of test in turn.
	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		trig = 3'b000;
		real_m = 1'b0;
		mute = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(`TTS_CTRL_ADDR, 32'h8, "ctrl reset");
		rd(`TTS_IRQ_EN_ADDR, 32'h0, "irq enable reset");
		rd(`TTS_IRQ_CLR_ADDR, 32'h0, "clear reads zero");
		rd(8'h14, 32'h0, "unmapped read");
		chk(32'(e), 32'h1, "unmapped error");
		apb(1'b1, `TTS_CTRL_ADDR, 32'h1);
		fire(3'b001);
		repeat (4) @(negedge pclk);
		chk(32'(busy), 32'h0, "start without guard first");
		apb(1'b1, `TTS_CTRL_ADDR, 32'hf);
		rd(`TTS_CTRL_ADDR, 32'hd, "real mode with three tones");
		apb(1'b1, `TTS_CTRL_ADDR, 32'h9);
		apb(1'b1, `TTS_IRQ_EN_ADDR, 32'h1);
		ce <= 1'b0;
		fire(3'b001);
		ce <= 1'b1;
		repeat (4) @(negedge pclk);
		chk(32'(busy), 32'h0, "start held off while clock enable low");
		fire(3'b001);
		span(0, 1500, "echo off");
		span(1, 500, "echo key");
		idle_wait();
		chk(32'({trip_out, echo_trip_out, irq}), 32'h3, "echo result");
		rd(`TTS_IRQ_STAT_ADDR, 32'h1, "pass event");
		apb(1'b1, `TTS_IRQ_CLR_ADDR, 32'h1);
		repeat (2) @(negedge pclk);
		chk(32'(irq), 32'h0, "irq cleared");
		real_m <= 1'b1;
		apb(1'b1, `TTS_CTRL_ADDR, 32'hb);
		fire(3'b010);
		span(0, 2000, "real off");
		span(1, 2000, "real key");
		idle_wait();
		chk(32'({trip_out, echo_trip_out}), 32'h3, "real result");
		real_m <= 1'b0;
		apb(1'b1, `TTS_CTRL_ADDR, 32'hd);
		apb(1'b1, `TTS_CTRL_ADDR, 32'h1d);
		span(0, 1500, "direct off");
		span(1, 500, "direct key");
		span(0, 1500, "unblock off");
		span(2, 500, "unblock key");
		idle_wait();
		chk(32'({trip_out, echo_trip_out, unblock_echo_out}), 32'h3, "three tone result");
		rd(`TTS_STATUS_ADDR, 32'h690, "three tone status");
		mute <= 1'b1;
		apb(1'b1, `TTS_CTRL_ADDR, 32'hd);
		apb(1'b1, `TTS_IRQ_CLR_ADDR, 32'hf);
		fire(3'b100);
		span(0, 2000, "answer off");
		span(1, 500, "answer key");
		chk(32'(first_echo_trip_output), 32'h1, "first echo");
		rd(`TTS_IRQ_STAT_ADDR, 32'h4, "answer event");
		apb(1'b1, `TTS_CTRL_ADDR, 32'h9);
		apb(1'b1, `TTS_IRQ_EN_ADDR, 32'ha);
		apb(1'b1, `TTS_IRQ_CLR_ADDR, 32'hf);
		fire(3'b001);
		fire(3'b010);
		rd(`TTS_IRQ_STAT_ADDR, 32'h8, "start while busy");
		chk(32'(irq), 32'h1, "irq on ignored start");
		idle_wait();
		rd(`TTS_IRQ_STAT_ADDR, 32'ha, "reply timeout");
		apb(1'b1, `TTS_CTRL_ADDR, 32'hb);
		fire(3'b100);
		span(1, 2000, "real answer key");
		chk(32'({trip_out, echo_trip_out}), 32'h1, "real answer echo only");
		conclude();
	end
endmodule
